/* rtl/shac_top.sv */
// acquisition sequencer for a 32-channel infinite sample-and-hold
`timescale 1ns/1ps
module shac_top (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_addr_strobe,
  input wire logic [shac_pkg::ADDR_WIDTH-1:0] i_channel_address,
  input wire logic i_offset_select,
  input wire logic i_all_channels,
  input wire logic i_infinite_hold_mode_n,
  input wire logic [shac_pkg::CODE_WIDTH-1:0] i_common_analog_input,
  output logic o_busy_n,
  output logic [shac_pkg::CHAN_COUNT-1:0] o_track_select,
  output logic [shac_pkg::CODE_WIDTH*shac_pkg::CHAN_COUNT-1:0]
    o_channel_output,
  output logic [shac_pkg::CODE_WIDTH-1:0] o_span_shift_output
);
  import shac_pkg::*;

  // ==========================================================
  // hold-release pulse width qualifier
  logic rel_prev_reg;
  logic rel_prev_next;
  logic [LOW_WIDTH-1:0] low_cnt_reg;
  logic [LOW_WIDTH-1:0] low_cnt_next;
  logic rise;
  logic soft_reset;
  logic long_low;

  // count low cycles, saturating just past the reset window
  always_comb begin
    rel_prev_next = i_infinite_hold_mode_n;
    low_cnt_next = low_cnt_reg;
    if (!i_infinite_hold_mode_n) begin
      if (low_cnt_reg != LOW_SAT) begin
        low_cnt_next = low_cnt_reg + LOW_WIDTH'(1);
      end
    end else begin
      low_cnt_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rel_prev_reg <= 1'b1;
      low_cnt_reg <= '0;
    end else if (i_ce) begin
      rel_prev_reg <= rel_prev_next;
      low_cnt_reg <= low_cnt_next;
    end
  end

  assign rise = i_infinite_hold_mode_n && !rel_prev_reg;
  // qualified reset pulse: ends inside 90..200 ns
  assign soft_reset = rise && (low_cnt_reg >= LOW_MIN) &&
    (low_cnt_reg <= LOW_MAX);
  // short pulses have no effect except in SHAC_WAIT, where any unqualified rise starts an acquisition
  assign long_low = rise && (low_cnt_reg > LOW_MAX);

  // ==========================================================
  // address decode
  logic [CHAN_COUNT-1:0] sel_mask;
  logic sel_offset;

  // offset select wins over the channel address bits
  always_comb begin
    sel_mask = '0;
    sel_offset = 1'b0;
    if (i_offset_select) begin
      sel_offset = 1'b1;
    end else if (i_all_channels) begin
      sel_mask = '1;
    end else begin
      sel_mask[i_channel_address] = 1'b1;
    end
  end

  // ==========================================================
  // acquisition sequencer
  shac_state_type state_reg;
  shac_state_type state_next;
  logic [CNT_WIDTH-1:0] cnt_reg;
  logic [CNT_WIDTH-1:0] cnt_next;
  logic [CNT_WIDTH-1:0] last_reg;
  logic [CNT_WIDTH-1:0] last_next;
  logic [CHAN_COUNT-1:0] tgt_reg;
  logic [CHAN_COUNT-1:0] tgt_next;
  logic tgt_off_reg;
  logic tgt_off_next;
  logic busy_n_next;
  logic load;

  // start at once if release is high, else wait for its rising edge
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    last_next = last_reg;
    tgt_next = tgt_reg;
    tgt_off_next = tgt_off_reg;
    busy_n_next = o_busy_n;
    load = 1'b0;
    case (state_reg)
      SHAC_IDLE, SHAC_WAIT: begin
        if (i_addr_strobe) begin
          tgt_next = sel_mask;
          tgt_off_next = sel_offset;
          last_next = i_all_channels && !i_offset_select ?
            ACQ_ALL_LAST : ACQ_SINGLE_LAST;
          cnt_next = '0;
          if (i_infinite_hold_mode_n) begin
            state_next = SHAC_ACQ;
            busy_n_next = 1'b0;
          end else begin
            state_next = SHAC_WAIT;
          end
        end else if (state_reg == SHAC_WAIT && (long_low ||
            (rise && !soft_reset))) begin
          state_next = SHAC_ACQ;
          busy_n_next = 1'b0;
          cnt_next = '0;
        end
      end
      SHAC_ACQ: begin
        if (cnt_reg == last_reg) begin
          load = 1'b1;
          busy_n_next = 1'b1;
          state_next = SHAC_IDLE;
          tgt_next = '0;
          tgt_off_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + CNT_WIDTH'(1);
        end
      end
      default: begin
        state_next = SHAC_IDLE;
      end
    endcase
    if (soft_reset) begin
      state_next = SHAC_IDLE;
      busy_n_next = 1'b1;
      tgt_next = '0;
      tgt_off_next = 1'b0;
      cnt_next = '0;
      load = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= SHAC_IDLE;
      cnt_reg <= '0;
      last_reg <= ACQ_SINGLE_LAST;
      tgt_reg <= '0;
      tgt_off_reg <= 1'b0;
      o_busy_n <= 1'b1;
    end else if (i_ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      last_reg <= last_next;
      tgt_reg <= tgt_next;
      tgt_off_reg <= tgt_off_next;
      o_busy_n <= busy_n_next;
    end
  end

  // ==========================================================
  // hold converters: 32 channels plus the span shift channel
  logic [CODE_WIDTH-1:0] code_reg [CHAN_COUNT+1];
  logic [CODE_WIDTH-1:0] code_next [CHAN_COUNT+1];
  logic [CHAN_COUNT-1:0] track_next;
  logic [CODE_WIDTH*CHAN_COUNT-1:0] out_next;

  // only targeted converters load; the rest keep their code
  always_comb begin
    for (int i = 0; i < CHAN_COUNT; i++) begin
      code_next[i] = code_reg[i];
      if (load && tgt_reg[i]) begin
        code_next[i] = i_common_analog_input;
      end
    end
    code_next[CHAN_COUNT] = code_reg[CHAN_COUNT];
    if (load && tgt_off_reg) begin
      code_next[CHAN_COUNT] = i_common_analog_input;
    end
    if (soft_reset) begin
      for (int i = 0; i <= CHAN_COUNT; i++) begin
        code_next[i] = CODE_RESET;
      end
    end
    // a tracking channel shows the live input instead of its code
    for (int i = 0; i < CHAN_COUNT; i++) begin
      track_next[i] = (state_next != SHAC_IDLE) && tgt_next[i];
      out_next[i*CODE_WIDTH +: CODE_WIDTH] = track_next[i] ?
        i_common_analog_input : code_next[i];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int i = 0; i <= CHAN_COUNT; i++) begin
        code_reg[i] <= CODE_RESET;
      end
      o_track_select <= '0;
      o_channel_output <= '0;
      o_span_shift_output <= CODE_RESET;
    end else if (i_ce) begin
      for (int i = 0; i <= CHAN_COUNT; i++) begin
        code_reg[i] <= code_next[i];
      end
      o_track_select <= track_next;
      o_channel_output <= out_next;
      o_span_shift_output <= code_next[CHAN_COUNT];
    end
  end
endmodule

/* rtl/shac_pkg.sv */
// package of constants for the sample-and-hold acquire control block
// ============================================================
package shac_pkg;
  // ==========================================================
  // widths and counts
  localparam int CHAN_COUNT = 32;
  localparam int ADDR_WIDTH = 5;
  localparam int CODE_WIDTH = 14;
  localparam logic [CODE_WIDTH-1:0] CODE_RESET = 14'h0000;
  // ==========================================================
  // timing, figures in their own units
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ACQ_SINGLE_NS = 16000;
  localparam int ACQ_ALL_NS = 45000;
  localparam int RESET_MIN_NS = 90;
  localparam int RESET_MAX_NS = 200;
  // least times round up, longest times round down
  localparam int ACQ_SINGLE_CYC = (ACQ_SINGLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACQ_ALL_CYC = (ACQ_ALL_NS * 1000) / CLK_PERIOD_PS;
  localparam int RESET_MIN_CYC =
    (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_MAX_CYC = (RESET_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_WIDTH = 14;
  localparam int LOW_WIDTH = 8;
  localparam logic [CNT_WIDTH-1:0] ACQ_SINGLE_LAST =
    CNT_WIDTH'(ACQ_SINGLE_CYC - 1);
  localparam logic [CNT_WIDTH-1:0] ACQ_ALL_LAST = CNT_WIDTH'(ACQ_ALL_CYC - 1);
  localparam logic [LOW_WIDTH-1:0] LOW_MIN = LOW_WIDTH'(RESET_MIN_CYC);
  localparam logic [LOW_WIDTH-1:0] LOW_MAX = LOW_WIDTH'(RESET_MAX_CYC);
  localparam logic [LOW_WIDTH-1:0] LOW_SAT = LOW_WIDTH'(RESET_MAX_CYC + 1);
  // ==========================================================
  // acquisition states
  typedef enum logic [1:0] {
    SHAC_IDLE,
    SHAC_WAIT,
    SHAC_ACQ
  } shac_state_type;
endpackage

/* test/shac_top_properties.sv */
// assertion checker for the acquisition sequencer ports
`timescale 1ns/1ps
module shac_top_properties (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_addr_strobe,
  input wire logic [4:0] i_channel_address,
  input wire logic i_offset_select,
  input wire logic i_all_channels,
  input wire logic i_infinite_hold_mode_n,
  input wire logic o_busy_n,
  input wire logic [31:0] o_track_select,
  input wire logic [447:0] o_channel_output
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  logic [13:0] low_reg;
  logic go;
  // a strobe that must start an acquisition at once
  assign go = i_addr_strobe && i_infinite_hold_mode_n && o_busy_n && i_ce;
  // enabled cycles that busy has been seen low
  always_ff @(posedge i_clk) begin
    if (i_srst || o_busy_n) begin
      low_reg <= 14'h0000;
    end else if (i_ce) begin
      low_reg <= low_reg + 14'h0001;
    end
  end
  AST_IDLE: assert property (disable iff (1'b0) i_srst |=> o_busy_n)
    else $error("busy low after reset");
  AST_START: assert property (go |=> !o_busy_n)
    else $error("no start");
  AST_SPAN: assert property ($rose(o_busy_n) |-> low_reg == 14'h0FA0
    || low_reg == 14'h2BF2) else $error("busy length wrong");
  AST_LIMIT: assert property (!o_busy_n |-> low_reg < 14'h2BF2)
    else $error("busy too long");
  AST_ONE: assert property (go && !i_offset_select && !i_all_channels
    |=> o_track_select == 32'h1 << $past(i_channel_address))
    else $error("wrong track bit");
  AST_ALL: assert property (go && !i_offset_select && i_all_channels
    |=> &o_track_select) else $error("not all tracking");
  AST_OFFS: assert property (go && i_offset_select
    |=> o_track_select == 32'h0 && !o_busy_n) else $error("offset pick");
  AST_DONE: assert property ($rose(o_busy_n) |-> o_track_select == 0)
    else $error("track left on");
  AST_HOLD: assert property (o_busy_n && $past(o_busy_n) &&
    o_track_select == 0 && $past(o_track_select) == 0 &&
    $past(i_infinite_hold_mode_n) && $past(i_infinite_hold_mode_n, 2) &&
    $past(i_infinite_hold_mode_n, 3) |-> $stable(o_channel_output))
    else $error("held code moved");
  cover property ($rose(o_busy_n));
  cover property (go && i_all_channels);
  cover property (i_addr_strobe && !i_infinite_hold_mode_n);
endmodule
bind shac_top shac_top_properties chk (.i_clk, .i_srst, .i_ce, .i_addr_strobe,
  .i_channel_address, .i_offset_select, .i_all_channels,
  .i_infinite_hold_mode_n, .o_busy_n, .o_track_select, .o_channel_output);

/* test/shac_host_model.sv */
// host model driving channel addressing and the hold-release line
`timescale 1ns/1ps
module shac_host_model (
  input wire logic i_clk,
  output logic o_strobe,
  output logic [4:0] o_addr,
  output logic o_offs,
  output logic o_all,
  output logic o_release_n
);
  // idle levels: release pulled high, the rest pulled low
  initial begin
    o_strobe = 1'b0;
    o_addr = 5'h00;
    o_offs = 1'b0;
    o_all = 1'b0;
    o_release_n = 1'b1;
  end
  // one-cycle address strobe, address scrambled once released
  task automatic pick(input logic [4:0] a, input logic s, input logic l);
    @(posedge i_clk) #1;
    o_strobe = 1'b1;
    o_addr = a;
    o_offs = s;
    o_all = l;
    @(posedge i_clk) #1;
    o_strobe = 1'b0;
    o_addr = ~a;
  endtask
  // hold-release level change, used for pulses too
  task automatic hold(input logic v);
    @(posedge i_clk) #1;
    o_release_n = v;
  endtask
endmodule

/* test/test_sample_hold_acquire_control.sv */
// self-checking bench for the sample-and-hold acquire control block
`timescale 1ns/1ps
module test_sample_hold_acquire_control;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic ce = 1'b1;
  logic strb, offs, alls, rel_n, busy_n;
  logic [4:0] addr;
  logic [13:0] common_analog_input = 14'h0000;
  logic [13:0] span;
  logic [31:0] trk;
  logic [447:0] outs;
  int err_count = 0;
  int tests_run = 0;
  int n;
  always #2 i_clk = ~i_clk;
  shac_host_model host (.i_clk, .o_strobe(strb), .o_addr(addr),
    .o_offs(offs), .o_all(alls), .o_release_n(rel_n));
  shac_top DUT (.i_clk, .i_srst, .i_ce(ce), .i_addr_strobe(strb),
    .i_channel_address(addr), .i_offset_select(offs),
    .i_all_channels(alls), .i_infinite_hold_mode_n(rel_n),
    .i_common_analog_input(common_analog_input), .o_busy_n(busy_n), .o_track_select(trk),
    .o_channel_output(outs), .o_span_shift_output(span));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [13:0] code(input int ch);
    return outs[14*ch +: 14];
  endfunction
  task automatic close_out();
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  // bounded wait for busy to rise
  task automatic done();
    n = 0;
    while (busy_n !== 1'b1 && n < 12000) begin
      step(1);
      n++;
    end
    if (busy_n !== 1'b1) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic t_single(input int ch, input logic [13:0] v);
    common_analog_input = v;
    host.pick(ch[4:0], 1'b0, 1'b0);
    check(busy_n, 0);
    check(trk, 32'h1 << ch);
    check(code(ch), v);
    done();
    check(n <= 4000, 1);
    check(code(ch), v);
    common_analog_input = ~v;
    step(4);
    check(code(ch), v);
  endtask
  task automatic t_offset();
    common_analog_input = 14'h2A5C;
    host.pick(5'h07, 1'b1, 1'b1);
    check(trk, 0);
    done();
    check(span, 14'h2A5C);
    check(code(7), 0);
  endtask
  task automatic t_glitch();
    host.hold(1'b0);
    step(9);
    host.hold(1'b1);
    step(3);
    check(code(0), 14'h0001);
    check(busy_n, 1);
  endtask
  task automatic t_track();
    host.hold(1'b0);
    host.pick(5'h05, 1'b0, 1'b0);
    common_analog_input = 14'h1234;
    step(60);
    check(busy_n, 1);
    check(trk, 32'h20);
    check(code(5), 14'h1234);
    host.hold(1'b1);
    step(2);
    check(busy_n, 0);
    done();
    check(code(5), 14'h1234);
  endtask
  task automatic t_all();
    common_analog_input = 14'h3FFF;
    host.pick(5'h00, 1'b0, 1'b1);
    check(trk, 32'hFFFFFFFF);
    done();
    for (int c = 0; c < 32; c++) check(code(c), 14'h3FFF);
  endtask
  // clock enable low near the end of an acquisition stretches it
  task automatic t_freeze();
    common_analog_input = 14'h0155;
    host.pick(5'h03, 1'b0, 1'b0);
    step(3990);
    ce = 1'b0;
    step(50);
    check(busy_n, 0);
    check(trk, 32'h8);
    ce = 1'b1;
    done();
    check(code(3), 14'h0155);
  endtask
  task automatic t_reset();
    host.hold(1'b0);
    step(29);
    host.hold(1'b1);
    step(3);
    check(span, 0);
    for (int c = 0; c < 32; c++) check(code(c), 0);
    check(busy_n, 1);
  endtask
  initial begin
    step(16);
    i_srst = 1'b0;
    check(busy_n, 1);
    for (int c = 0; c < 32; c++) check(code(c), 0);
    check(span, 0);
    t_offset();
    t_single(0, 14'h0001);
    t_single(31, 14'h3FFE);
    t_glitch();
    t_track();
    t_all();
    t_freeze();
    t_reset();
    close_out();
  end
endmodule
